// ### inc/clock_switch_pkg.sv
/*
 * shared constants, types and register map of the two-source clock switch.
 * assumes a single system clock that oversamples both clock sources.
 */
package clock_switch_pkg;

    // ************************************************************
    // register port
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // ************************************************************
    // output mode setting
    // ************************************************************
    localparam int MODE_W = 4;
    localparam int MODE_LSB = 0;
    typedef enum logic [3:0] {
        MODE_BUF_FIRST = 4'h0,
        MODE_BUF_SECOND = 4'h1,
        MODE_RISING = 4'h2,
        MODE_FALLING = 4'h3,
        MODE_SECOND_GATE_LOW = 4'h4,
        MODE_SECOND_GATE_HIGH = 4'h5,
        MODE_FIRST_GATE_LOW = 4'h6,
        MODE_FIRST_GATE_HIGH = 4'h7,
        MODE_CONST_HIGH = 4'h8,
        MODE_CONST_LOW = 4'h9
    } output_mode_setting_t;
    localparam output_mode_setting_t MODE_RESET = MODE_BUF_FIRST;

    // ************************************************************
    // handover state and status layout
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DROP = 2'b01,
        ST_WAKE = 2'b10
    } handover_state_t;
    localparam int STATUS_W = 5;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int STAT_BYPASS_BIT = 3;
    localparam int STAT_SEL_BIT = 4;

    typedef struct packed {
        logic sel;
        logic bypass;
        handover_state_t state;
        logic active;
    } status_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    localparam int NUM_SRC = 2;

endpackage

// ### rtl/edge_seq.sv
/*
 * watches one sampled clock source for an ordered pair of edges.
 * assumes level and previous level come from consecutive samples.
 */
`timescale 1ns/100ps
module edge_seq
    import clock_switch_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic arm_in,
    input wire logic rise_first_in,
    input wire logic level_in,
    input wire logic prev_in,
    output logic done_out
);

    // ************************************************************
    // edge decode
    // ************************************************************
    logic got_first_r;
    wire rise_w = level_in & ~prev_in;
    wire fall_w = ~level_in & prev_in;
    wire first_w = rise_first_in ? rise_w : fall_w;
    wire second_w = rise_first_in ? fall_w : rise_w;

    // ************************************************************
    // first edge memory
    // ************************************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            got_first_r <= 1'h0;
        end else if (!arm_in) begin
            got_first_r <= 1'h0;
        end else if (first_w) begin
            got_first_r <= 1'h1;
        end
    end

    assign done_out = arm_in & got_first_r & second_w;

endmodule

// ### rtl/reg_port.sv
/*
 * register slave: mode setting and read-only status.
 * assumes one-cycle strobes; read data valid only in the cycle after.
 */
`timescale 1ns/100ps
module reg_port
    import clock_switch_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire reg_req_t req_in,
    input wire status_t status_in,
    output output_mode_setting_t mode_out,
    output logic [DATA_W-1:0] rdata_out
);

    // ************************************************************
    // address decode
    // ************************************************************
    output_mode_setting_t mode_r;
    logic [DATA_W-1:0] rdata_r;
    wire hit_mode_w = (req_in.addr == OFF_MODE);
    wire hit_status_w = (req_in.addr == OFF_STATUS);
    wire [DATA_W-1:0] mode_word_w = {{(DATA_W-MODE_W){1'h0}}, mode_r};
    wire [DATA_W-1:0] status_word_w = {{(DATA_W-STATUS_W){1'h0}}, status_in};
    wire [DATA_W-1:0] read_word_w = hit_mode_w ? mode_word_w :
                                    hit_status_w ? status_word_w : DATA_ZERO;

    // ************************************************************
    // storage
    // ************************************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_r <= MODE_RESET;
        end else if (req_in.wr && hit_mode_w) begin
            mode_r <= output_mode_setting_t'(req_in.wdata[MODE_LSB +: MODE_W]);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= DATA_ZERO;
        end else begin
            rdata_r <= req_in.rd ? read_word_w : DATA_ZERO;
        end
    end

    assign mode_out = mode_r;
    assign rdata_out = rdata_r;

endmodule

// ### rtl/glitchless_clock_switch.sv
/*
 * two-source clock switch with glitch-free rising or falling handover,
 * fixed and gated output modes, and an immediate bypass.
 * assumes both sources are oversampled by clk_in; select and bypass
 * come from core logic synchronous to clk_in.
 */
// Overview of operation
// - route one of two clocks, runtime select
// - glitch-free handover only with bypass low
// - bypass may change anytime, followed dynamically
// - bypass switches immediately; select picks source
// - rising mode: rise-fall current, rise-fall target
// - rising mode holds output low between
// - falling mode: fall-rise current, fall-rise target
// - falling mode holds output high between
// - handover modes: select 0 first, 1 second
// - default mode buffers first clock, reset value
// - buffer-second mode ignores select
// - second gate low: 0 or second clock
// - second gate high: 1 or second clock
// - first gate low: first clock or 0
// - first gate high: first clock or 1
// - constant high and constant low modes
// - reset keeps output quiet until release
`timescale 1ns/100ps
module glitchless_clock_switch
    import clock_switch_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic first_clock_in,
    input wire logic second_clock_in,
    input wire logic select_in,
    input wire logic bypass_select_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    output logic switched_clock_out
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [NUM_SRC-1:0] src_smp_r;
    logic [NUM_SRC-1:0] src_prev_r;
    logic sel_r;
    logic bypass_r;
    logic cur_r;
    logic cur_nxt;
    logic out_r;
    logic out_nxt;
    handover_state_t state_r;
    handover_state_t state_nxt;
    output_mode_setting_t mode_w;
    status_t status_w;
    reg_req_t req_w;
    logic [NUM_SRC-1:0] arm_w;
    logic [NUM_SRC-1:0] done_w;

    // ************************************************************
    // register port
    // ************************************************************
    assign req_w.addr = reg_addr_in;
    assign req_w.wdata = reg_wdata_in;
    assign req_w.wr = reg_wr_in;
    assign req_w.rd = reg_rd_in;

    assign status_w.sel = sel_r;
    assign status_w.bypass = bypass_r;
    assign status_w.state = state_r;
    assign status_w.active = cur_r;

    reg_port u_regs (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .req_in(req_w),
        .status_in(status_w),
        .mode_out(mode_w),
        .rdata_out(reg_rdata_out)
    );

    // ************************************************************
    // input sampling
    // ************************************************************
    // bypass followed live
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_smp_r <= 2'h0;
            src_prev_r <= 2'h0;
            sel_r <= 1'h0;
            bypass_r <= 1'h0;
        end else begin
            src_smp_r <= {second_clock_in, first_clock_in};
            src_prev_r <= src_smp_r;
            sel_r <= select_in;
            bypass_r <= bypass_select_in;
        end
    end

    // ************************************************************
    // mode decode
    // ************************************************************
    wire is_hand_mode_w = (mode_w == MODE_RISING) || (mode_w == MODE_FALLING);
    wire hand_w = is_hand_mode_w && !bypass_r;
    wire rise_first_w = (mode_w == MODE_RISING);
    wire hold_level_w = (mode_w == MODE_FALLING);
    wire first_w = src_smp_r[0];
    wire second_w = src_smp_r[1];
    wire sel_pick_w = sel_r ? second_w : first_w;
    wire cur_pick_w = cur_r ? second_w : first_w;
    wire drop_done_w = done_w[cur_r];
    wire wake_done_w = done_w[~cur_r];

    // ************************************************************
    // per-source edge watchers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            // ordered edges on current then target
            assign arm_w[gi] = hand_w &&
                ((state_r == ST_DROP && cur_r == 1'(gi)) ||
                 (state_r == ST_WAKE && cur_r != 1'(gi)));
            edge_seq u_seq (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .arm_in(arm_w[gi]),
                .rise_first_in(rise_first_w),
                .level_in(src_smp_r[gi]),
                .prev_in(src_prev_r[gi]),
                .done_out(done_w[gi])
            );
        end
    endgenerate

    // ************************************************************
    // handover state machine
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        if (!hand_w) begin
            // bypass and fixed modes track select at once
            state_nxt = ST_RUN;
            cur_nxt = sel_r;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (sel_r != cur_r) begin
                        state_nxt = ST_DROP;
                    end
                end
                ST_DROP: begin
                    if (drop_done_w) begin
                        state_nxt = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_done_w) begin
                        state_nxt = ST_RUN;
                        cur_nxt = ~cur_r;
                    end
                end
                default: begin
                    state_nxt = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ST_RUN;
            cur_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
        end
    end

    // ************************************************************
    // output selection
    // ************************************************************
    always_comb begin
        case (mode_w)
            MODE_BUF_FIRST: out_nxt = first_w;
            MODE_BUF_SECOND: out_nxt = second_w;
            MODE_RISING, MODE_FALLING: begin
                if (bypass_r) begin
                    out_nxt = sel_pick_w;
                end else if (state_r == ST_WAKE) begin
                    out_nxt = hold_level_w;
                end else begin
                    out_nxt = cur_pick_w;
                end
            end
            MODE_SECOND_GATE_LOW: out_nxt = sel_r ? second_w : 1'h0;
            MODE_SECOND_GATE_HIGH: out_nxt = sel_r ? second_w : 1'h1;
            MODE_FIRST_GATE_LOW: out_nxt = sel_r ? 1'h0 : first_w;
            MODE_FIRST_GATE_HIGH: out_nxt = sel_r ? 1'h1 : first_w;
            MODE_CONST_HIGH: out_nxt = 1'h1;
            MODE_CONST_LOW: out_nxt = 1'h0;
            default: out_nxt = 1'h0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_r <= 1'h0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign switched_clock_out = out_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb_main @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_handover_start;
        state_r == ST_RUN && hand_w && sel_r != cur_r;
    endsequence

    sequence s_drop_to_wake;
        (state_r == ST_DROP) ##1 (state_r == ST_WAKE);
    endsequence

    sequence s_wake_finish;
        state_r == ST_WAKE && hand_w && wake_done_w;
    endsequence

    property p_start;
        s_handover_start |=> (state_r == ST_DROP) && (cur_r == $past(cur_r));
    endproperty
    a_start: assert property (p_start) else $error("handover did not start");

    property p_drop_cause;
        s_drop_to_wake |-> $past(drop_done_w) && $past(hand_w);
    endproperty
    a_drop_cause: assert property (p_drop_cause) else $error("current dropped early");

    property p_finish;
        s_wake_finish |=> (state_r == ST_RUN) && (cur_r != $past(cur_r));
    endproperty
    a_finish: assert property (p_finish) else $error("target not taken");

    property p_stall;
        (state_r == ST_WAKE && hand_w && !wake_done_w) |=> (state_r == ST_WAKE);
    endproperty
    a_stall: assert property (p_stall) else $error("handover left without edges");

    property p_rise_hold;
        (state_r == ST_WAKE && mode_w == MODE_RISING && !bypass_r) |=> !out_r;
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("rising hold not low");

    property p_fall_hold;
        (state_r == ST_WAKE && mode_w == MODE_FALLING && !bypass_r) |=> out_r;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("falling hold not high");

    property p_run_pass;
        (state_r == ST_RUN && hand_w) |=> (out_r == $past(cur_pick_w));
    endproperty
    a_run_pass: assert property (p_run_pass) else $error("active source not passed");

    property p_bypass;
        (bypass_r && is_hand_mode_w) |=> (out_r == $past(sel_pick_w));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not immediate");

    property p_bypass_abort;
        (bypass_r && state_r != ST_RUN) |=> (state_r == ST_RUN) && (cur_r == $past(sel_r));
    endproperty
    a_bypass_abort: assert property (p_bypass_abort) else $error("bypass ignored");

    property p_buf_first;
        (mode_w == MODE_BUF_FIRST) |=> (out_r == $past(first_w));
    endproperty
    a_buf_first: assert property (p_buf_first) else $error("first not buffered");

    property p_buf_second;
        (mode_w == MODE_BUF_SECOND) |=> (out_r == $past(second_w));
    endproperty
    a_buf_second: assert property (p_buf_second) else $error("second not buffered");

    property p_second_low;
        (mode_w == MODE_SECOND_GATE_LOW) |=> (out_r == ($past(sel_r) && $past(second_w)));
    endproperty
    a_second_low: assert property (p_second_low) else $error("second gate low wrong");

    property p_second_high;
        (mode_w == MODE_SECOND_GATE_HIGH) |=> (out_r == (!$past(sel_r) || $past(second_w)));
    endproperty
    a_second_high: assert property (p_second_high) else $error("second gate high wrong");

    property p_first_low;
        (mode_w == MODE_FIRST_GATE_LOW) |=> (out_r == (!$past(sel_r) && $past(first_w)));
    endproperty
    a_first_low: assert property (p_first_low) else $error("first gate low wrong");

    property p_first_high;
        (mode_w == MODE_FIRST_GATE_HIGH) |=> (out_r == ($past(sel_r) || $past(first_w)));
    endproperty
    a_first_high: assert property (p_first_high) else $error("first gate high wrong");

    property p_const;
        (mode_w == MODE_CONST_HIGH) |=> out_r;
    endproperty
    a_const: assert property (p_const) else $error("constant high broken");

    property p_const_low;
        (mode_w == MODE_CONST_LOW) |=> !out_r;
    endproperty
    a_const_low: assert property (p_const_low) else $error("constant low broken");

    property p_bypass_follow;
        $changed(bypass_select_in) |=> (bypass_r == $past(bypass_select_in));
    endproperty
    a_bypass_follow: assert property (p_bypass_follow) else $error("bypass not followed");

endmodule

// ### sim/clock_source_model.sv
/*
 * source model: two slow independent clocks made from clk_in, each
 * of which can be stopped at its present level.
 * assumes clk_in runs well above twice either source rate.
 */
`timescale 1ns/100ps
module clock_source_model #(
    parameter int HALF_FIRST = 6,
    parameter int HALF_SECOND = 7
) (
    input wire logic clk_in,
    input wire logic run_first_in,
    input wire logic run_second_in,
    output logic first_clock_out,
    output logic second_clock_out
);
    // ************************************************************
    // sources
    // ************************************************************
    int cnt_first_r = 0;
    int cnt_second_r = 0;
    logic first_r = 1'b0;
    logic second_r = 1'b0;

    always @(posedge clk_in) begin
        if (run_first_in) begin
            cnt_first_r <= (cnt_first_r == HALF_FIRST - 1) ? 0 : cnt_first_r + 1;
            if (cnt_first_r == HALF_FIRST - 1)
                first_r <= ~first_r;
        end
    end

    always @(posedge clk_in) begin
        if (run_second_in) begin
            cnt_second_r <= (cnt_second_r == HALF_SECOND - 1) ? 0 : cnt_second_r + 1;
            if (cnt_second_r == HALF_SECOND - 1)
                second_r <= ~second_r;
        end
    end

    assign first_clock_out = first_r;
    assign second_clock_out = second_r;
endmodule

// ### sim/glitchless_clock_switch_tb_top.sv
/*
 * bench: register port, output modes, handovers, bypass and reset.
 * assumes the source model drives both clocks; select and bypass
 * are driven here as the core logic would.
 */
`timescale 1ns/100ps
module glitchless_clock_switch_tb_top
    import clock_switch_pkg::*;
();
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic sel = 1'b1;
    logic byp = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run0 = 1'b1;
    logic run1 = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic a;
    logic b;
    logic out;
    logic [3:0] ha = 4'h0;
    logic [3:0] hb = 4'h0;
    logic [3:0] ml [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    int fail_count = 0;
    int n_tests = 0;

    clock_source_model clock_source_model_inst (
        .clk_in(clk_in),
        .run_first_in(run0),
        .run_second_in(run1),
        .first_clock_out(a),
        .second_clock_out(b)
    );

    glitchless_clock_switch glitchless_clock_switch_inst (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .first_clock_in(a),
        .second_clock_in(b),
        .select_in(sel),
        .bypass_select_in(byp),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata),
        .switched_clock_out(out)
    );

    initial forever #2 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        ha <= {ha[2:0], a};
        hb <= {hb[2:0], b};
    end

    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic f(input logic [3:0] m, input logic s, input logic x, input logic y);
        case (m)
            4'h0: f = x;
            4'h1: f = y;
            4'h2, 4'h3: f = s ? y : x;
            4'h4: f = s & y;
            4'h5: f = ~s | y;
            4'h6: f = ~s & x;
            4'h7: f = s | x;
            4'h8: f = 1'b1;
            default: f = 1'b0;
        endcase
    endfunction

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic put(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic get(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        addr <= ad;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(negedge clk_in);
        chk(rdata, e);
    endtask

    // compares only where both sources stood still over the lag
    task automatic watch(input logic [3:0] m, input int n);
        repeat (n) begin
            @(negedge clk_in);
            if ((ha == 4'h0 || ha == 4'hF) && (hb == 4'h0 || hb == 4'hF))
                chk(32'(out), 32'(f(m, sel, ha[0], hb[0])));
        end
    endtask

    task automatic hold(input logic v, input int n);
        repeat (n) begin
            @(negedge clk_in);
            chk(32'(out), 32'(v));
        end
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        conclude();
    end

    initial begin
        hold(1'b0, 20);
        @(posedge clk_in);
        rstn_in <= 1'b1;
        get(OFF_MODE, 32'h0);
        step(4);
        watch(4'h0, 30);
        put(OFF_STATUS, 32'hFF);
        get(OFF_STATUS, 32'h11);
        put(8'h08, 32'h5);
        get(8'h08, 32'h0);
        get(OFF_MODE, 32'h0);
        put(OFF_MODE, 32'hFFFF_FFF7);
        get(OFF_MODE, 32'h7);
        $display("test registers done");
        foreach (ml[i]) for (int s = 0; s < 2; s++) begin
            put(OFF_MODE, {28'h0, ml[i]});
            sel <= s[0];
            step(4);
            watch(ml[i], 30);
        end
        $display("test modes done");
        sel <= 1'b0;
        step(4);
        put(OFF_MODE, 32'h2);
        step(10);
        watch(4'h2, 30);
        step(1);
        run0 <= 1'b0;
        sel <= 1'b1;
        step(20);
        get(OFF_STATUS, 32'h12);
        step(1);
        run1 <= 1'b0;
        run0 <= 1'b1;
        step(30);
        get(OFF_STATUS, 32'h14);
        hold(1'b0, 30);
        step(1);
        run1 <= 1'b1;
        step(40);
        get(OFF_STATUS, 32'h11);
        watch(4'h2, 30);
        $display("test rising handover done");
        put(OFF_MODE, 32'h3);
        run0 <= 1'b0;
        sel <= 1'b0;
        step(40);
        get(OFF_STATUS, 32'h05);
        hold(1'b1, 30);
        step(1);
        byp <= 1'b1;
        step(4);
        get(OFF_STATUS, 32'h08);
        watch(4'h2, 10);
        step(1);
        sel <= 1'b1;
        step(4);
        watch(4'h2, 30);
        step(1);
        byp <= 1'b0;
        sel <= 1'b0;
        step(40);
        get(OFF_STATUS, 32'h05);
        step(1);
        run0 <= 1'b1;
        step(40);
        get(OFF_STATUS, 32'h00);
        watch(4'h3, 30);
        $display("test falling handover and bypass done");
        step(1);
        rstn_in <= 1'b0;
        hold(1'b0, 10);
        step(1);
        rstn_in <= 1'b1;
        get(OFF_MODE, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule
